/* common/timer_block_pkg.sv */
package timer_block_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CORE_CTRL_OFFSET = 8'h00;
  localparam logic [7:0] AUX_CTRL_OFFSET = 8'h04;
  localparam logic [7:0] CAPTURE_RELOAD_REGISTER_OFFSET = 8'h08;
  localparam logic [7:0] CORE_TIMER_OFFSET = 8'h0C;
  localparam logic [7:0] AUX_TIMER_OFFSET = 8'h10;
  localparam logic [7:0] STATUS_OFFSET = 8'h14;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] TIMER_RESET = 16'h0000;
  localparam logic [15:0] CAPTURE_RELOAD_REGISTER_RESET = 16'h0000;
  localparam logic [15:0] TIMER_MAX = 16'hFFFF;

  // ----------------------------------------------------------------
  // Control field positions, shared by both control registers
  // ----------------------------------------------------------------
  localparam int ISEL_LSB = 0;
  localparam int MODE_LSB = 3;
  localparam int RUN_BIT = 6;
  localparam int DIR_BIT = 7;
  // Core control only
  localparam int TOGGLE_BIT = 10;
  localparam int PRESC_LSB = 11;
  localparam int RELOAD_EN_BIT = 15;
  // Auxiliary control only
  localparam int REMOTE_RUN_BIT = 8;
  localparam int CLEAR_ON_CAP_BIT = 9;
  localparam int CAP_CORR_BIT = 10;
  localparam int EDGE_SEL_LSB = 11;
  localparam int FOREIGN_SEL_BIT = 13;
  localparam int CAP_EN_BIT = 14;
  // Status register
  localparam int CAP_FLAG_BIT = 0;
  localparam int CORE_FLAG_BIT = 1;

  // Writable bits of each control register
  localparam logic [15:0] CORE_CTRL_MASK = 16'h98FF;
  localparam logic [15:0] AUX_CTRL_MASK = 16'h7FFF;

  // ----------------------------------------------------------------
  // Mode encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_TIMER = 3'h0;
  localparam logic [2:0] MODE_COUNTER = 3'h1;
  localparam logic [2:0] MODE_GATED_LOW = 3'h2;
  localparam logic [2:0] MODE_GATED_HIGH = 3'h3;

  // Block prescaler: log2 of the base divisor per field value
  localparam logic [3:0] PRESC_EXP_00 = 4'h2;
  localparam logic [3:0] PRESC_EXP_01 = 4'h1;
  localparam logic [3:0] PRESC_EXP_10 = 4'h4;
  localparam logic [3:0] PRESC_EXP_11 = 4'h3;
  localparam int PRESC_CNT_W = 12;

  // ----------------------------------------------------------------
  // Pin bundle
  // ----------------------------------------------------------------
  typedef struct packed {
    logic capture_pin;
    logic foreign_count_input;
    logic foreign_direction_input;
    logic core_count_pin;
    logic aux_count_pin;
  } pins_t;

  localparam int PIN_COUNT = 5;
  localparam int PIN_CAPTURE = 4;
  localparam int PIN_FOREIGN_COUNT = 3;
  localparam int PIN_FOREIGN_DIR = 2;
  localparam int PIN_CORE_COUNT = 1;
  localparam int PIN_AUX_COUNT = 0;

endpackage

/* verilog/capture_reload_timer_block.sv */
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ps

// Overview of operation
// - Core timer counts only while run set
// - Aux run bit, or core run when remote
// - Direction bit 0 up, 1 down, anytime
// - Core wrap toggles latch; software sets too
// - Timer mode: clock over prescaler times 2^isel
// - Aux same frequencies, no latch or output
// - Both latch edges: 32-bit chain
// - One latch edge: 33-bit chain
// - Chained directions independent, core any mode
// - Capture enable bit; source pin or foreign
// - Edge select: pin edges or foreign inputs
// - Foreign transitions latch aux into capture reg
// - Pin trigger captures aux, sets capture flag
// - Clear-on-capture zeroes aux after latching
// - Disabled capture still clears; pin trigger still flags
// - Reload enabled: core wrap loads capture reg
// - Reload sets core flag, not capture flag
// - Capture and reload work together
// - Correction captures aux value minus one
// - Core wrap pulse output for other timers
// - All registers reset to zero
module capture_reload_timer_block
  import timer_block_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External pins
  input wire pins_t pins_in,
  // Timer outputs
  output logic core_overflow_out,
  output logic core_toggle_latch,
  output logic capture_irq_flag,
  output logic core_irq_flag
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [15:0] core_ctrl_reg;
  logic [15:0] aux_ctrl_reg;
  logic [15:0] capture_reload_reg;
  logic [15:0] core_timer_reg;
  logic [15:0] aux_timer_reg;
  logic toggle_reg;
  logic cap_flag_reg;
  logic core_flag_reg;
  logic ovf_out_reg;
  logic [PRESC_CNT_W-1:0] presc_cnt_reg;

  logic [PIN_COUNT-1:0] pin_raw;
  logic [PIN_COUNT-1:0] pin_meta_reg;
  logic [PIN_COUNT-1:0] pin_sync_reg;
  logic [PIN_COUNT-1:0] pin_prev_reg;
  logic [PIN_COUNT-1:0] pin_rise;
  logic [PIN_COUNT-1:0] pin_fall;

  logic wr_access;
  logic rd_setup;
  logic addr_ok;
  logic [15:0] wdata16;
  logic [15:0] core_ctrl_view;
  logic [15:0] status_view;
  logic [31:0] rd_mux;

  logic [2:0] core_mode;
  logic [2:0] aux_mode;
  logic [2:0] core_isel;
  logic [2:0] aux_isel;
  logic [3:0] presc_exp;
  logic core_tick;
  logic aux_tick;
  logic core_run;
  logic aux_run;
  logic core_dir;
  logic aux_dir;
  logic core_count_en;
  logic aux_count_en;
  logic core_wrap;
  logic latch_rise;
  logic latch_fall;
  logic pin_trig;
  logic foreign_trig;
  logic cap_trig;
  logic do_capture;
  logic do_clear;
  logic [15:0] capture_value;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Tick once per 2^exp cycles of the free-running prescaler
  function automatic logic tick_of(input logic [PRESC_CNT_W-1:0] cnt, input logic [3:0] exp);
    logic [PRESC_CNT_W-1:0] mask;
    mask = PRESC_CNT_W'((PRESC_CNT_W'(1) << exp) - PRESC_CNT_W'(1));
    return (cnt & mask) == mask;
  endfunction

  // Edge code: bit 0 rising, bit 1 falling
  function automatic logic edge_hit(input logic [1:0] sel, input logic rise, input logic fall);
    return (sel[0] & rise) | (sel[1] & fall);
  endfunction

  function automatic logic [15:0] step(input logic [15:0] v, input logic down);
    return down ? 16'(v - 16'h0001) : 16'(v + 16'h0001);
  endfunction

  // Count enable from mode, prescaler tick, gate level and count edge
  function automatic logic mode_enable(input logic [2:0] mode, input logic tick, input logic gate,
                                       input logic cnt_edge);
    logic en;
    en = 1'b0;
    case (mode)
      MODE_TIMER: en = tick;
      MODE_COUNTER: en = cnt_edge;
      MODE_GATED_LOW: en = tick & ~gate;
      MODE_GATED_HIGH: en = tick & gate;
      default: en = 1'b0;
    endcase
    return en;
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers and edge detection
  // ----------------------------------------------------------------
  assign pin_raw = pins_in;

  // Edges compare the second stage with its own delayed copy only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
      pin_prev_reg <= '0;
    end else begin
      pin_meta_reg <= pin_raw;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  assign pin_rise = pin_sync_reg & ~pin_prev_reg;
  assign pin_fall = ~pin_sync_reg & pin_prev_reg;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // Zero wait states: read data is fetched in the setup cycle
  assign pready = 1'b1;
  assign wr_access = psel & penable & pwrite & addr_ok;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign wdata16 = pwdata[15:0];

  always_comb begin
    addr_ok = 1'b1;
    unique case (paddr)
      CORE_CTRL_OFFSET, AUX_CTRL_OFFSET, CAPTURE_RELOAD_REGISTER_OFFSET,
      CORE_TIMER_OFFSET, AUX_TIMER_OFFSET, STATUS_OFFSET: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  assign pslverr = psel & penable & ~addr_ok;

  always_comb begin
    core_ctrl_view = core_ctrl_reg;
    core_ctrl_view[TOGGLE_BIT] = toggle_reg;
    status_view = 16'h0000;
    status_view[CAP_FLAG_BIT] = cap_flag_reg;
    status_view[CORE_FLAG_BIT] = core_flag_reg;
    rd_mux = 32'h00000000;
    unique case (paddr)
      CORE_CTRL_OFFSET: rd_mux[15:0] = core_ctrl_view;
      AUX_CTRL_OFFSET: rd_mux[15:0] = aux_ctrl_reg;
      CAPTURE_RELOAD_REGISTER_OFFSET: rd_mux[15:0] = capture_reload_reg;
      CORE_TIMER_OFFSET: rd_mux[15:0] = core_timer_reg;
      AUX_TIMER_OFFSET: rd_mux[15:0] = aux_timer_reg;
      STATUS_OFFSET: rd_mux[15:0] = status_view;
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      prdata <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_ctrl_reg <= CTRL_RESET;
      aux_ctrl_reg <= CTRL_RESET;
    end else if (wr_access) begin
      if (paddr == CORE_CTRL_OFFSET) begin
        core_ctrl_reg <= wdata16 & CORE_CTRL_MASK;
      end
      if (paddr == AUX_CTRL_OFFSET) begin
        aux_ctrl_reg <= wdata16 & AUX_CTRL_MASK;
      end
    end
  end

  assign core_mode = core_ctrl_reg[MODE_LSB +: 3];
  assign aux_mode = aux_ctrl_reg[MODE_LSB +: 3];
  assign core_isel = core_ctrl_reg[ISEL_LSB +: 3];
  assign aux_isel = aux_ctrl_reg[ISEL_LSB +: 3];
  assign core_dir = core_ctrl_reg[DIR_BIT];
  assign aux_dir = aux_ctrl_reg[DIR_BIT];

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  always_comb begin
    unique case (core_ctrl_reg[PRESC_LSB +: 2])
      2'h0: presc_exp = PRESC_EXP_00;
      2'h1: presc_exp = PRESC_EXP_01;
      2'h2: presc_exp = PRESC_EXP_10;
      2'h3: presc_exp = PRESC_EXP_11;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_cnt_reg <= '0;
    end else begin
      presc_cnt_reg <= PRESC_CNT_W'(presc_cnt_reg + PRESC_CNT_W'(1));
    end
  end

  // Shared counter keeps the two timers phase-aligned
  assign core_tick = tick_of(presc_cnt_reg, 4'(presc_exp + {1'b0, core_isel}));
  assign aux_tick = tick_of(presc_cnt_reg, 4'(presc_exp + {1'b0, aux_isel}));

  // ----------------------------------------------------------------
  // Core timer
  // ----------------------------------------------------------------
  assign core_run = core_ctrl_reg[RUN_BIT];
  assign core_count_en = core_run & mode_enable(core_mode, core_tick, pin_sync_reg[PIN_CORE_COUNT],
    edge_hit(core_isel[1:0], pin_rise[PIN_CORE_COUNT], pin_fall[PIN_CORE_COUNT]));
  assign core_wrap = core_count_en &
    (core_dir ? (core_timer_reg == TIMER_RESET) : (core_timer_reg == TIMER_MAX));

  // A software write beats a same-cycle reload or count step;
  // writes take priority so a load is never lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_timer_reg <= TIMER_RESET;
    end else if (wr_access && paddr == CORE_TIMER_OFFSET) begin
      core_timer_reg <= wdata16;
    end else if (core_wrap && core_ctrl_reg[RELOAD_EN_BIT]) begin
      core_timer_reg <= capture_reload_reg;
    end else if (core_count_en) begin
      core_timer_reg <= step(core_timer_reg, core_dir);
    end
  end

  // Only hardware toggles feed the aux chain; software writes do not
  assign latch_rise = core_wrap & ~toggle_reg;
  assign latch_fall = core_wrap & toggle_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      toggle_reg <= 1'b0;
    end else if (wr_access && paddr == CORE_CTRL_OFFSET) begin
      toggle_reg <= wdata16[TOGGLE_BIT] ^ core_wrap;
    end else if (core_wrap) begin
      toggle_reg <= ~toggle_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_out_reg <= 1'b0;
    end else begin
      ovf_out_reg <= core_wrap;
    end
  end

  assign core_overflow_out = ovf_out_reg;
  assign core_toggle_latch = toggle_reg;

  // ----------------------------------------------------------------
  // Auxiliary timer
  // ----------------------------------------------------------------
  assign aux_run = aux_ctrl_reg[REMOTE_RUN_BIT] ? core_run : aux_ctrl_reg[RUN_BIT];

  // isel[2] picks the core latch edges instead of the aux pin
  assign aux_count_en = aux_run & mode_enable(aux_mode, aux_tick, pin_sync_reg[PIN_AUX_COUNT],
    aux_isel[2] ? edge_hit(aux_isel[1:0], latch_rise, latch_fall)
                : edge_hit(aux_isel[1:0], pin_rise[PIN_AUX_COUNT], pin_fall[PIN_AUX_COUNT]));

  // ----------------------------------------------------------------
  // Capture trigger
  // ----------------------------------------------------------------
  assign pin_trig = ~aux_ctrl_reg[FOREIGN_SEL_BIT] &
    edge_hit(aux_ctrl_reg[EDGE_SEL_LSB +: 2], pin_rise[PIN_CAPTURE], pin_fall[PIN_CAPTURE]);
  assign foreign_trig = aux_ctrl_reg[FOREIGN_SEL_BIT] &
    edge_hit(aux_ctrl_reg[EDGE_SEL_LSB +: 2],
             pin_rise[PIN_FOREIGN_COUNT] | pin_fall[PIN_FOREIGN_COUNT],
             pin_rise[PIN_FOREIGN_DIR] | pin_fall[PIN_FOREIGN_DIR]);
  assign cap_trig = pin_trig | foreign_trig;
  assign do_capture = cap_trig & aux_ctrl_reg[CAP_EN_BIT];
  // Pin edges clear even with capture disabled
  assign do_clear = cap_trig & aux_ctrl_reg[CLEAR_ON_CAP_BIT];
  assign capture_value = aux_ctrl_reg[CAP_CORR_BIT] ? 16'(aux_timer_reg - 16'h0001)
                                                    : aux_timer_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_timer_reg <= TIMER_RESET;
    end else if (wr_access && paddr == AUX_TIMER_OFFSET) begin
      aux_timer_reg <= wdata16;
    end else if (do_clear) begin
      aux_timer_reg <= TIMER_RESET;
    end else if (aux_count_en) begin
      aux_timer_reg <= step(aux_timer_reg, aux_dir);
    end
  end

  // Hardware capture beats a same-cycle software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_reload_reg <= CAPTURE_RELOAD_REGISTER_RESET;
    end else if (do_capture) begin
      capture_reload_reg <= capture_value;
    end else if (wr_access && paddr == CAPTURE_RELOAD_REGISTER_OFFSET) begin
      capture_reload_reg <= wdata16;
    end
  end

  // ----------------------------------------------------------------
  // Request flags (write one to clear, set wins)
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_flag_reg <= 1'b0;
    end else if (pin_trig || do_capture) begin
      cap_flag_reg <= 1'b1;
    end else if (wr_access && paddr == STATUS_OFFSET && wdata16[CAP_FLAG_BIT]) begin
      cap_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_flag_reg <= 1'b0;
    end else if (core_wrap) begin
      core_flag_reg <= 1'b1;
    end else if (wr_access && paddr == STATUS_OFFSET && wdata16[CORE_FLAG_BIT]) begin
      core_flag_reg <= 1'b0;
    end
  end

  assign capture_irq_flag = cap_flag_reg;
  assign core_irq_flag = core_flag_reg;

endmodule // capture_reload_timer_block

/* verif/capture_reload_timer_monitor.sv */
`timescale 1ns/1ps

module capture_reload_timer_monitor
  import timer_block_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and timer outputs
  input wire pins_t pins_in,
  input wire logic core_overflow_out,
  input wire logic core_toggle_latch,
  input wire logic capture_irq_flag,
  input wire logic core_irq_flag
);
  logic mapped;
  logic ctrl_wr;
  logic stat_wr;
  logic [2:0] trig_pins;
  assign mapped = paddr inside {CORE_CTRL_OFFSET, AUX_CTRL_OFFSET, CAPTURE_RELOAD_REGISTER_OFFSET, CORE_TIMER_OFFSET,
                                AUX_TIMER_OFFSET, STATUS_OFFSET};
  assign ctrl_wr = psel && penable && pwrite && paddr == CORE_CTRL_OFFSET;
  assign stat_wr = psel && penable && pwrite && paddr == STATUS_OFFSET;
  assign trig_pins = pins_in[4:2];

  default clocking mon_cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_ready; psel && penable |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("access phase without ready");
  property p_err; psel && penable |-> pslverr == !mapped; endproperty
  a_err: assert property (p_err) else $error("slave error does not follow address map");
  property p_upper; psel && penable && !pwrite |-> prdata[31:16] == 16'h0000 && (mapped || prdata == '0); endproperty
  a_upper: assert property (p_upper) else $error("read data has stray bits");
  property p_ovf_pulse; core_overflow_out |=> !core_overflow_out; endproperty
  a_ovf_pulse: assert property (p_ovf_pulse) else $error("overflow output longer than one cycle");
  // Toggle moves only by a wrap or by a control write
  property p_toggle_cause; $changed(core_toggle_latch) && !$past(ctrl_wr) |-> ##[0:1] core_overflow_out; endproperty
  a_toggle_cause: assert property (p_toggle_cause) else $error("toggle latch moved without a wrap");
  property p_irq_cause; $rose(core_irq_flag) |-> ##[0:1] core_overflow_out; endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("core flag set without a wrap");
  property p_ovf_flag; core_overflow_out |-> core_irq_flag || $past(core_irq_flag); endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("wrap did not set core flag");
  // Two synchroniser stages plus the flag register
  property p_cap_cause; $rose(capture_irq_flag) |-> $past(trig_pins, 3) != $past(trig_pins, 4); endproperty
  a_cap_cause: assert property (p_cap_cause) else $error("capture flag without a pin edge");
  property p_cap_hold; $fell(capture_irq_flag) |-> $past(stat_wr && pwdata[CAP_FLAG_BIT]); endproperty
  a_cap_hold: assert property (p_cap_hold) else $error("capture flag dropped by itself");
  property p_core_hold; $fell(core_irq_flag) |-> $past(stat_wr && pwdata[CORE_FLAG_BIT]); endproperty
  a_core_hold: assert property (p_core_hold) else $error("core flag dropped by itself");

  c_ovf: cover property (core_overflow_out && core_irq_flag);
  c_cap: cover property ($rose(capture_irq_flag));
  c_err: cover property (psel && penable && pslverr);
endmodule // capture_reload_timer_monitor

bind capture_reload_timer_block capture_reload_timer_monitor mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins_in(pins_in),
  .core_overflow_out(core_overflow_out), .core_toggle_latch(core_toggle_latch),
  .capture_irq_flag(capture_irq_flag), .core_irq_flag(core_irq_flag)
);

/* verif/pin_source_model.sv */
`timescale 1ns/1ps

module pin_source_model
  import timer_block_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Requested levels and pacing
  input wire pins_t want,
  input wire logic [3:0] hold_len,
  // Pin levels
  output pins_t pins_out
);
  logic [3:0] held_reg;
  // Requests arriving too early wait; a faster source would lose edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_out <= '0;
      held_reg <= 4'h0;
    end else if (held_reg != 4'h0) begin
      held_reg <= held_reg - 4'h1;
    end else if (want != pins_out) begin
      pins_out <= want;
      held_reg <= hold_len - 4'h1;
    end
  end
endmodule // pin_source_model

/* verif/tb_top.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin error_cnt++; \
  $display("Error %s expected %0h seen %0h", nm, ex, got); end end

module tb_top;
  import timer_block_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, core_overflow_out, core_toggle_latch, capture_irq_flag, core_irq_flag;
  pins_t want = '0;
  pins_t pins_in;
  logic [3:0] hold_len = 4'h2;
  int error_cnt = 0;
  int num_checks = 0;
  int ovf_cnt = 0;
  int rise_cnt = 0;
  logic tl_prev = 1'b0;

  always #50 pclk = ~pclk;

  capture_reload_timer_block uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pins_in(pins_in), .core_overflow_out(core_overflow_out), .core_toggle_latch(core_toggle_latch),
    .capture_irq_flag(capture_irq_flag), .core_irq_flag(core_irq_flag));
  pin_source_model src (.pclk(pclk), .presetn(presetn), .want(want), .hold_len(hold_len), .pins_out(pins_in));

  always @(posedge pclk) begin
    if (core_overflow_out === 1'b1) ovf_cnt++;
    if (core_toggle_latch === 1'b1 && tl_prev === 1'b0) rise_cnt++;
    tl_prev = core_toggle_latch;
  end

  // ----------------------------------------------------------------
  // Bus and helpers
  // ----------------------------------------------------------------
  task automatic xfer(input logic [7:0] a, input logic w, input logic [15:0] d, output logic [15:0] r,
                      output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) error_cnt++;
    r = prdata[15:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] r;
    logic e;
    xfer(a, 1'b1, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] r, output logic e);
    xfer(a, 1'b0, 16'h0000, r, e);
  endtask

  task automatic wait_ovf;
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (core_overflow_out !== 1'b1 && n < 2000);
    if (n >= 2000) error_cnt++;
  endtask

  function automatic int period(input logic [1:0] ps, input logic [2:0] is);
    case (ps)
      2'b00: return 4 << is;
      2'b01: return 2 << is;
      2'b10: return 16 << is;
      default: return 8 << is;
    endcase
  endfunction

  function automatic logic near(input int d, input int ex);
    return d >= ex - 1 && d <= ex + 1;
  endfunction

  function automatic logic cap_trig(input logic fs, input logic [1:0] ed, input int idx, input logic rise);
    if (!fs) return idx == PIN_CAPTURE && (rise ? ed[0] : ed[1]);
    return (idx == PIN_FOREIGN_COUNT && ed[0]) || (idx == PIN_FOREIGN_DIR && ed[1]);
  endfunction

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge pclk);
    error_cnt++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    logic [15:0] v, r, ex_cap;
    logic e, t0, dn, en, clr, corr, fs, old, trig;
    logic [1:0] ed;
    logic [2:0] isl;
    int p, d, c0, idx;
    p = $urandom(41273);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(8'(4 * i), r, e);
      `CHK("reset_val", 16'h0000, r)
    end
    rd(8'h18, r, e);
    `CHK("unmapped", 1'b1, e)
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      isl = 3'($urandom % 3);
      dn = 1'($urandom % 2);
      p = period(2'(i), isl);
      wr(CORE_TIMER_OFFSET, 16'h8000);
      wr(CORE_CTRL_OFFSET, {3'b000, 2'(i), 3'b000, dn, 1'b1, MODE_TIMER, isl});
      repeat (200) @(posedge pclk);
      wr(CORE_CTRL_OFFSET, {3'b000, 2'(i), 3'b000, dn, 1'b0, MODE_TIMER, isl});
      rd(CORE_TIMER_OFFSET, r, e);
      d = dn ? 32768 - int'(r) : int'(r) - 32768;
      `CHK("core_rate", 1'b1, near(d, 202 / p))
      repeat (20) @(posedge pclk);
      rd(CORE_TIMER_OFFSET, v, e);
      `CHK("core_stopped", r, v)
    end
    $display("test rate done");
    for (int i = 0; i < 4; i++) begin
      {dn, en} = 2'(i);
      wr(CAPTURE_RELOAD_REGISTER_OFFSET, dn ? 16'h0010 : 16'hFFF0);
      wr(CORE_TIMER_OFFSET, dn ? 16'h0001 : 16'hFFFE);
      wr(STATUS_OFFSET, 16'h0003);
      wr(CORE_CTRL_OFFSET, {en, 4'b0001, 3'b000, dn, 1'b1, MODE_TIMER, 3'b000});
      // Without reload the next wrap is a full 16-bit span away
      for (int k = 0; k < (en ? 3 : 1); k++) begin
        t0 = core_toggle_latch;
        wait_ovf();
        `CHK("toggle", ~t0, core_toggle_latch)
      end
      `CHK("core_flag", 1'b1, core_irq_flag)
      `CHK("no_cap_flag", 1'b0, capture_irq_flag)
      wr(CORE_CTRL_OFFSET, 16'h0000);
      rd(CORE_TIMER_OFFSET, r, e);
      v = en ? (dn ? 16'h0010 : 16'hFFF0) : (dn ? 16'hFFFF : 16'h0000);
      d = dn ? int'(v) - int'(r) : int'(r) - int'(v);
      `CHK("reload", 1'b1, d >= 0 && d < 6)
    end
    wr(CORE_CTRL_OFFSET, 16'h0400);
    @(posedge pclk);
    `CHK("toggle_set", 1'b1, core_toggle_latch)
    wr(CORE_CTRL_OFFSET, 16'h0000);
    @(posedge pclk);
    `CHK("toggle_clr", 1'b0, core_toggle_latch)
    wr(STATUS_OFFSET, 16'h0003);
    @(posedge pclk);
    `CHK("core_flag_clr", 1'b0, core_irq_flag)
    $display("test wrap done");
    for (int i = 0; i < 2; i++) begin
      wr(CORE_TIMER_OFFSET, 16'h0000);
      wr(AUX_TIMER_OFFSET, 16'h0100);
      wr(AUX_CTRL_OFFSET, i ? 16'h0000 : 16'h0100);
      wr(CORE_CTRL_OFFSET, i ? 16'h0858 : 16'h0850);
      repeat (40) @(posedge pclk);
      wr(CORE_CTRL_OFFSET, 16'h0000);
      rd(AUX_TIMER_OFFSET, r, e);
      `CHK("remote_run", 1'b1, i ? (r === 16'h0100) : near(int'(r) - 256, 21))
      rd(CORE_TIMER_OFFSET, v, e);
      `CHK("gated", 1'b1, i ? (v === 16'h0000) : near(int'(v), 21))
    end
    $display("test remote done");
    for (int i = 0; i < 2; i++) begin
      dn = 1'($urandom % 2);
      wr(CAPTURE_RELOAD_REGISTER_OFFSET, 16'hFFFC);
      wr(CORE_TIMER_OFFSET, 16'hFFFC);
      wr(AUX_TIMER_OFFSET, 16'h8000);
      wr(AUX_CTRL_OFFSET, {8'h00, dn, 1'b1, MODE_COUNTER, i ? 3'b101 : 3'b111});
      c0 = ovf_cnt;
      p = rise_cnt;
      wr(CORE_CTRL_OFFSET, 16'h8840);
      repeat (6) wait_ovf();
      @(posedge pclk);
      d = i ? rise_cnt - p : ovf_cnt - c0;
      wr(CORE_CTRL_OFFSET, 16'h0000);
      rd(AUX_TIMER_OFFSET, r, e);
      `CHK("chain", 16'(dn ? 32768 - d : 32768 + d), r)
    end
    $display("test chain done");
    wr(CAPTURE_RELOAD_REGISTER_OFFSET, 16'h1234);
    ex_cap = 16'h1234;
    for (int i = 0; i < 32; i++) begin
      v = 16'($urandom % 65534 + 1);
      ed = i[1:0];
      fs = i[2];
      idx = (i[4:3] == 2'd1) ? PIN_FOREIGN_COUNT : (i[4:3] == 2'd2) ? PIN_FOREIGN_DIR : PIN_CAPTURE;
      {en, clr, corr} = 3'($urandom);
      wr(AUX_TIMER_OFFSET, v);
      wr(AUX_CTRL_OFFSET, {1'b0, en, fs, ed, corr, clr, 9'h000});
      wr(STATUS_OFFSET, 16'h0003);
      old = want[idx];
      hold_len <= 4'(2 + $urandom % 3);
      want[idx] <= ~old;
      repeat (12) @(posedge pclk);
      trig = cap_trig(fs, ed, idx, ~old);
      if (trig && en) ex_cap = corr ? v - 16'h0001 : v;
      rd(CAPTURE_RELOAD_REGISTER_OFFSET, r, e);
      `CHK("capture", ex_cap, r)
      rd(AUX_TIMER_OFFSET, r, e);
      `CHK("aux_clear", (trig && clr) ? 16'h0000 : v, r)
      `CHK("cap_flag", (trig && !fs) || (trig && en), capture_irq_flag)
    end
    $display("test capture done");
    stop_test();
  end
endmodule // tb_top
